// >>> shared/odf_pkg.sv
`default_nettype none
package odf_pkg;
  localparam int CH_N      = 8;
  localparam int PIN_N     = 4;
  localparam int LIMP_CH   = 4;
  localparam int WORD_W    = 16;
  localparam int CNT_W     = 8;
  localparam int BYTE_BITS = 3;

  localparam logic [CNT_W-1:0]  MIN_FRAME = 8'h10;
  localparam logic [CNT_W-1:0]  CNT_FIRST = 8'h01;
  localparam logic [WORD_W-1:0] CMD_RST   = 16'hffff;
  localparam logic              TER_RST   = 1'b1;

  localparam logic [1:0] CMD_STBY  = 2'h0;
  localparam logic [1:0] CMD_INPUT = 2'h1;
  localparam logic [1:0] CMD_ON    = 2'h2;
  localparam logic [1:0] CMD_OFF   = 2'h3;

  typedef enum logic [1:0] {
    MD_UNDERVOLTAGE_LOCKOUT,
    MD_LOWIQ,
    MD_NORMAL,
    MD_LIMP
  } odf_mode_type;

  typedef struct packed {
    logic logic_ok;
    logic analog_ok;
    logic enable;
    logic limp;
  } odf_ctrl_type;

  typedef struct packed {
    logic [CH_N-1:0] overload;
    logic [CH_N-1:0] overtemp;
    logic [CH_N-1:0] open_load;
  } odf_sense_type;

  typedef struct packed {
    logic              tog;
    logic              wrap;
    logic [CNT_W-1:0]  cnt;
    logic [WORD_W-1:0] word;
  } odf_frame_type;
endpackage : odf_pkg
`default_nettype wire

// >>> rtl/odf_sync.sv
`default_nettype none
module odf_sync #(
  parameter int W = 1
) (
  input  wire logic         clk,
  input  wire logic         rst_n,
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta_reg;

  // first stage feeds only the second stage
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_reg <= '0;
      q        <= '0;
    end else begin
      meta_reg <= d;
      q        <= meta_reg;
    end
  end
endmodule : odf_sync
`default_nettype wire

// >>> rtl/odf_spi_link.sv
`default_nettype none
module odf_spi_link (
  input  wire logic                          sclk,
  input  wire logic                          rst_n,
  input  wire logic                          chip_select_low,
  input  wire logic                          serial_in,
  input  wire logic                          tx_ter,
  input  wire logic [odf_pkg::WORD_W-1:0]    tx_status,
  output odf_pkg::odf_frame_type             frame,
  output logic                               serial_out,
  output logic                               serial_out_oe
);
  import odf_pkg::*;

  logic              frame_rst_n;
  logic              started_reg;
  logic              so_reg;
  logic              tog_reg;
  logic              wrap_reg;
  logic              carry;
  logic [CNT_W-1:0]  cnt_reg;
  logic [CNT_W-1:0]  cnt_next;
  logic [WORD_W-1:0] rx_reg;

  // the frame's own select ends it; no sclk edge is relied on after the last
  assign frame_rst_n = rst_n & ~chip_select_low;
  assign {carry, cnt_next} = {1'b0, cnt_reg} + {1'b0, CNT_FIRST};

  always_ff @(posedge sclk or negedge frame_rst_n) begin
    if (!frame_rst_n) begin
      started_reg <= 1'b0;
    end else begin
      started_reg <= 1'b1;
    end
  end

  // count and history persist past the frame so the system side can read them
  always_ff @(posedge sclk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_reg  <= '0;
      wrap_reg <= 1'b0;
      tog_reg  <= 1'b0;
    end else if (!started_reg) begin
      cnt_reg  <= CNT_FIRST;
      wrap_reg <= 1'b0;
      tog_reg  <= ~tog_reg;
    end else begin
      cnt_reg  <= cnt_next;
      wrap_reg <= wrap_reg | carry;
    end
  end

  always_ff @(negedge sclk or negedge rst_n) begin
    if (!rst_n) begin
      rx_reg <= '0;
    end else begin
      rx_reg <= {rx_reg[WORD_W-2:0], serial_in};
    end
  end

  always_ff @(posedge sclk or negedge rst_n) begin
    if (!rst_n) begin
      so_reg <= 1'b0;
    end else if (!started_reg) begin
      so_reg <= tx_status[WORD_W-1];
    end else if (!wrap_reg && cnt_reg < CNT_W'(WORD_W)) begin
      so_reg <= tx_status[~cnt_reg[3:0]];
    end else begin
      so_reg <= rx_reg[WORD_W-1];
    end
  end

  // before the first edge the flag is mixed with upstream data for the chain
  assign serial_out    = started_reg ? so_reg : (tx_ter | serial_in);
  assign serial_out_oe = ~chip_select_low;
  assign frame         = '{tog: tog_reg, wrap: wrap_reg, cnt: cnt_reg, word: rx_reg};

  cnt_step_a: assert property (@(posedge sclk) disable iff (!rst_n || chip_select_low)
    (started_reg && !(&cnt_reg)) |=> (cnt_reg == $past(cnt_reg) + CNT_FIRST))
    else $error("frame bit count did not advance by one");

  first_status_a: assert property (@(posedge sclk) disable iff (!rst_n || chip_select_low)
    (started_reg && cnt_reg == CNT_FIRST) |-> (so_reg == tx_status[WORD_W-1]))
    else $error("first clocked bit is not the top status bit");
endmodule : odf_spi_link
`default_nettype wire

// >>> rtl/odf_top.sv
`default_nettype none
// What this block does
// - eight channels each latch off alone on over-temperature
// - open-load judged only while driver off; flag never blocks switching
// - power-up global off keeps diagnostic current disabled
// - standby command clears only that channel's fault bits
// - supply resets, enable low, limp exit clear every fault bit
// - input word holds two command bits, output two status bits, per channel
// - sixteen-bit words, most significant bit first
// - overload latches channel off until cleared by command
// - limp mode keeps fault detection and reporting, ignores commands
// - frame length not multiple of eight or under sixteen sets error flag
// - error flag shown on serial out from select fall to first clock rise
// - error flag set leaving lockout, limp or low-current into global off
// - well framed command clears error flag
// - serial input ORed into error flag bit for daisy chain
// - error flag readable by select fall alone, no clocks
// - serial input sampled on falling clock edge
// - serial output changes on rising clock edge
// - received word taken only for valid frame lengths
// - length counter loads one on first rising clock after select fall, steps on rising clock
// - command codes: standby-clear, parallel input, on, off
// - status shifted out: error flag, then open-load and fault per channel
// - parallel inputs one to four drive channel pairs 1/5 to 4/8
// - after power-on reset all command bits are one, channels off
module odf_top (
  input  wire logic                        mclk,
  input  wire logic                        rst_n,
  input  wire odf_pkg::odf_ctrl_type       ctrl_pins,
  input  wire logic [odf_pkg::PIN_N-1:0]   parallel_input_n,
  input  wire odf_pkg::odf_sense_type      sense,
  input  wire logic                        sclk,
  input  wire logic                        chip_select_low,
  input  wire logic                        serial_in,
  output logic      [odf_pkg::CH_N-1:0]    channel_output_n,
  output logic      [odf_pkg::CH_N-1:0]    diag_current_en,
  output logic                             serial_out,
  output logic                             serial_out_oe
);
  import odf_pkg::*;

  localparam int SYNC_W = 4 + PIN_N + 3 * CH_N + 2;

  logic [SYNC_W-1:0] sync_d;
  logic [SYNC_W-1:0] sync_q;
  odf_ctrl_type      ctrl_s;
  logic [PIN_N-1:0]  pin_s;
  odf_sense_type     sense_s;
  logic              csb_s;
  logic              sel_s;
  logic              tog_s;
  odf_frame_type     frame;

  odf_mode_type      mode_reg;
  odf_mode_type      mode_next;
  logic              por;
  logic              enter_normal;
  logic              clear_all;

  logic              csb_d_reg;
  logic              tog_seen_reg;
  logic              frame_end;
  logic              had_edges;
  logic              frame_ok;
  logic              bad_frame;
  logic              accept;

  logic [WORD_W-1:0] cmd_reg;
  logic              diag_armed_reg;
  logic              ter_reg;
  logic              ter_set;
  logic [WORD_W-1:0] status;
  logic [WORD_W-1:0] tx_status_reg;
  logic              tx_ter_reg;

  logic [CH_N-1:0]   fault_flag_n;
  logic [CH_N-1:0]   open_load_flag_n;
  logic [CH_N-1:0]   fault_set_vec;
  logic [CH_N-1:0]   ol_set_vec;
  logic [CH_N-1:0]   stby_vec;

  // the frame word and count are only read once select is back high,
  // when no clock moves them; the toggle tells whether any edge came
  // select goes through inverted so the synchroniser's reset value matches idle
  assign sync_d = {ctrl_pins, parallel_input_n, sense, ~chip_select_low, frame.tog};

  odf_sync #(
    .W     (SYNC_W)
  ) u_sync (
    .clk   (mclk),
    .rst_n (rst_n),
    .d     (sync_d),
    .q     (sync_q)
  );

  assign {ctrl_s, pin_s, sense_s, sel_s, tog_s} = sync_q;
  assign csb_s = ~sel_s;

  // status words are frozen while selected, so the link reads stable bits
  odf_spi_link u_link (
    .sclk            (sclk),
    .rst_n           (rst_n),
    .chip_select_low (chip_select_low),
    .serial_in       (serial_in),
    .tx_ter          (tx_ter_reg),
    .tx_status       (tx_status_reg),
    .frame           (frame),
    .serial_out      (serial_out),
    .serial_out_oe   (serial_out_oe)
  );

  // in limp the logic supply reset is ignored
  always_comb begin
    por = !ctrl_s.analog_ok || (!ctrl_s.logic_ok && !ctrl_s.limp);
    if (por) begin
      mode_next = MD_UNDERVOLTAGE_LOCKOUT;
    end else if (ctrl_s.limp) begin
      mode_next = MD_LIMP;
    end else if (!ctrl_s.enable) begin
      mode_next = MD_LOWIQ;
    end else begin
      mode_next = MD_NORMAL;
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      mode_reg <= MD_UNDERVOLTAGE_LOCKOUT;
    end else begin
      mode_reg <= mode_next;
    end
  end

  assign enter_normal = (mode_next == MD_NORMAL) && (mode_reg != MD_NORMAL);
  assign clear_all    = (mode_next == MD_UNDERVOLTAGE_LOCKOUT) || (mode_next == MD_LOWIQ) ||
                        ((mode_reg == MD_LIMP) && (mode_next != MD_LIMP));

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      csb_d_reg    <= 1'b1;
      tog_seen_reg <= 1'b0;
    end else begin
      csb_d_reg <= csb_s;
      if (frame_end) begin
        tog_seen_reg <= tog_s;
      end
    end
  end

  assign frame_end = csb_s && !csb_d_reg;
  assign had_edges = tog_s != tog_seen_reg;
  assign frame_ok  = had_edges && (frame.cnt[BYTE_BITS-1:0] == '0) &&
                     (frame.wrap || frame.cnt >= MIN_FRAME);
  // a select pulse with no clocks only reads the flag and changes nothing
  assign bad_frame = frame_end && had_edges && !frame_ok;
  assign accept    = frame_end && frame_ok && (mode_reg == MD_NORMAL);

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      cmd_reg <= CMD_RST;
    end else if (clear_all) begin
      cmd_reg <= CMD_RST;
    end else if (accept) begin
      cmd_reg <= frame.word;
    end
  end

  // open-load current stays off after any entry until software commands
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      diag_armed_reg <= 1'b0;
    end else if (mode_reg != MD_NORMAL) begin
      diag_armed_reg <= 1'b0;
    end else if (accept) begin
      diag_armed_reg <= 1'b1;
    end
  end

  assign ter_set = enter_normal || bad_frame;

  // a setting event beats a clear in the same cycle
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      ter_reg <= TER_RST;
    end else begin
      ter_reg <= ter_set | (ter_reg & ~accept);
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      tx_status_reg <= '0;
      tx_ter_reg    <= TER_RST;
    end else if (csb_s && csb_d_reg) begin
      tx_status_reg <= status;
      tx_ter_reg    <= ter_reg;
    end
  end

  genvar i;
  for (i = 0; i < CH_N; i++) begin : g_ch
    logic [1:0] cmd;
    logic       pin;
    logic       on_req;
    logic       flt_reg;
    logic       ol_reg;
    logic       out_reg;
    logic       diag_reg;

    assign cmd = cmd_reg[2*i+1:2*i];
    assign pin = pin_s[i % PIN_N];

    always_comb begin
      unique case (mode_reg)
        MD_NORMAL: on_req = (cmd == CMD_ON) || ((cmd == CMD_INPUT) && pin);
        MD_LIMP:   on_req = (i < LIMP_CH) && pin;
        MD_UNDERVOLTAGE_LOCKOUT:   on_req = 1'b0;
        MD_LOWIQ:  on_req = 1'b0;
      endcase
    end

    assign stby_vec[i]      = (mode_reg == MD_NORMAL) && (cmd == CMD_STBY);
    // detectors stay live in limp; only lockout and low current mute them
    assign fault_set_vec[i] = ((mode_reg == MD_NORMAL) || (mode_reg == MD_LIMP)) &&
                              (sense_s.overload[i] || sense_s.overtemp[i]);
    assign ol_set_vec[i]    = sense_s.open_load[i] && !out_reg && diag_reg;

    always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
        flt_reg <= 1'b0;
      end else begin
        flt_reg <= fault_set_vec[i] | (flt_reg & ~(stby_vec[i] | clear_all));
      end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
        ol_reg <= 1'b0;
      end else begin
        ol_reg <= ol_set_vec[i] | (ol_reg & ~(stby_vec[i] | clear_all));
      end
    end

    // cut in the same edge the fault is seen; open-load never gates drive
    always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
        out_reg <= 1'b0;
      end else begin
        out_reg <= on_req & ~flt_reg & ~fault_set_vec[i];
      end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
        diag_reg <= 1'b0;
      end else begin
        diag_reg <= (mode_reg == MD_NORMAL) && diag_armed_reg && !on_req &&
                    ((cmd == CMD_OFF) || (cmd == CMD_INPUT));
      end
    end

    assign fault_flag_n[i]     = flt_reg;
    assign open_load_flag_n[i] = ol_reg;
    assign channel_output_n[i] = out_reg;
    assign diag_current_en[i]  = diag_reg;
    assign status[2*i+1]       = ol_reg;
    assign status[2*i]         = flt_reg;
  end

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!rst_n);

  fault_holds_off_a: assert property (
    (fault_flag_n & channel_output_n) == 8'h00)
    else $error("channel driven while its fault is latched");

  standby_clears_a: assert property (
    1'b1 |=> ((fault_flag_n & $past(stby_vec) & ~$past(fault_set_vec)) == 8'h00))
    else $error("standby left a fault bit set");

  reset_clears_a: assert property (
    (clear_all && fault_set_vec == 8'h00 && ol_set_vec == 8'h00)
    |=> (fault_flag_n == 8'h00 && open_load_flag_n == 8'h00))
    else $error("fault bits survived a clear-all condition");

  bad_frame_flag_a: assert property (
    bad_frame |=> ter_reg)
    else $error("bad frame length did not raise the error flag");

  bad_frame_keep_a: assert property (
    (frame_end && !frame_ok && !clear_all) |=> $stable(cmd_reg))
    else $error("command word changed on a bad frame");

  good_frame_clr_a: assert property (
    (accept && !ter_set) |=> !ter_reg)
    else $error("valid command did not clear the error flag");

  limp_ignore_a: assert property (
    (mode_reg == MD_LIMP && mode_next == MD_LIMP) |=> $stable(cmd_reg))
    else $error("command accepted in limp mode");

  limp_upper_off_a: assert property (
    (mode_reg == MD_LIMP) [*2] |-> (channel_output_n[CH_N-1:LIMP_CH] == 4'h0))
    else $error("upper channels on in limp mode");

  enter_off_flag_a: assert property (
    (mode_reg == MD_NORMAL && $past(mode_reg) != MD_NORMAL) |-> ter_reg)
    else $error("error flag not set on entry to global off");

  powerup_diag_a: assert property (
    ($past(mode_reg) != MD_NORMAL) |-> (diag_current_en == 8'h00))
    else $error("diagnostic current on right after power-up");

  accept_c: cover property (accept);
  bad_frame_c: cover property (bad_frame);
  limp_exit_c: cover property ((mode_reg == MD_LIMP) ##1 (mode_reg == MD_NORMAL));
  fault_latch_c: cover property ((|fault_set_vec) ##1 (|fault_flag_n));
endmodule : odf_top
`default_nettype wire

// >>> verification/odf_host.sv
`default_nettype none
// host side of the serial link: makes sclk only inside frames, 32 ns period
module odf_host (
  output logic      sclk,
  output logic      chip_select_low,
  output logic      serial_in,
  input  wire logic serial_out
);
  timeunit 1ns;
  timeprecision 1ps;

  initial begin
    sclk            = 1'b0;
    chip_select_low = 1'b1;
    serial_in       = 1'b0;
  end

  // n bits of din, msb first; dout collects serial_out at each falling edge
  task automatic xfer(input int n, input logic [31:0] din,
                      output logic [31:0] dout, output logic pre);
    dout = '0;
    #7.3;
    serial_in       = (n > 0) ? din[n-1] : din[0];
    chip_select_low = 1'b0;
    #120;
    pre = serial_out;
    for (int i = n - 1; i >= 0; i--) begin
      #2 serial_in = din[i];
      #14 sclk = 1'b1;
      #16 sclk = 1'b0;
      dout = {dout[30:0], serial_out};
    end
    #20 chip_select_low = 1'b1;
    // released line shows the inverse, never the last value
    #2 serial_in = ~serial_in;
    #120;
  endtask : xfer
endmodule : odf_host
`default_nettype wire

// >>> verification/test_octal_driver_spi_fault_logic.sv
`default_nettype none
module test_octal_driver_spi_fault_logic;
  import odf_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;

  logic               mclk;
  logic               rst_n;
  odf_ctrl_type       ctrl;
  logic [PIN_N-1:0]   pin;
  odf_sense_type      sense;
  logic               sclk;
  logic               csl;
  logic               si;
  logic [CH_N-1:0]    outn;
  logic [CH_N-1:0]    diag;
  logic               so;
  logic               so_oe;
  logic [31:0]        dout;
  logic               pre;
  logic [15:0]        c;
  logic [7:0]         eo;
  int                 n_fail;
  int                 n_tests;
  int                 bad_len [4] = '{8, 12, 17, 15};

  odf_top u_dut (
    .mclk             (mclk),
    .rst_n            (rst_n),
    .ctrl_pins        (ctrl),
    .parallel_input_n (pin),
    .sense            (sense),
    .sclk             (sclk),
    .chip_select_low  (csl),
    .serial_in        (si),
    .channel_output_n (outn),
    .diag_current_en  (diag),
    .serial_out       (so),
    .serial_out_oe    (so_oe)
  );

  odf_host u_host (
    .sclk            (sclk),
    .chip_select_low (csl),
    .serial_in       (si),
    .serial_out      (so)
  );

  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end

  function automatic logic [7:0] exp_drive(logic [15:0] w, logic [3:0] p);
    logic [7:0] e;
    for (int i = 0; i < CH_N; i++) begin
      e[i] = (w[2*i+:2] == CMD_ON) || (w[2*i+:2] == CMD_INPUT && p[i%PIN_N]);
    end
    return e;
  endfunction : exp_drive

  function automatic logic [7:0] exp_diag(logic [15:0] w, logic [7:0] on);
    logic [7:0] e;
    for (int i = 0; i < CH_N; i++) begin
      e[i] = !on[i] && (w[2*i+:2] == CMD_OFF || w[2*i+:2] == CMD_INPUT);
    end
    return e;
  endfunction : exp_diag

  function automatic logic [15:0] exp_stat(logic [7:0] ol, logic [7:0] f);
    logic [15:0] s;
    for (int i = 0; i < CH_N; i++) begin
      s[2*i+1] = ol[i];
      s[2*i]   = f[i];
    end
    return s;
  endfunction : exp_stat

  task automatic end_sim;
    if (n_fail == 0 && n_tests > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask : end_sim

  task automatic step(input int n);
    repeat (n) @(posedge mclk);
    #2;
  endtask : step

  task automatic send(input int n, input logic [31:0] d);
    u_host.xfer(n, d, dout, pre);
    step(3);
  endtask : send

  task automatic pulse(input logic [23:0] v);
    step(1);
    sense = v;
    step(5);
    sense = '0;
    step(4);
  endtask : pulse

  task automatic chk_drv(input logic [7:0] e_out, input logic [7:0] e_diag);
    n_tests++;
    if (outn !== e_out || diag !== e_diag || so_oe !== 1'b0) begin
      n_fail++;
      $display("ERROR %0t drive %h diag %h exp %h %h", $time, outn, diag, e_out, e_diag);
    end
  endtask : chk_drv

  task automatic chk_ser(input logic [31:0] e);
    n_tests++;
    if (dout !== e) begin
      n_fail++;
      $display("ERROR %0t serial word %h exp %h", $time, dout, e);
    end
  endtask : chk_ser

  // select fall alone, no clocks: the flag appears ORed with serial_in
  task automatic chk_ter(input logic s, input logic e);
    u_host.xfer(0, {31'h0, s}, dout, pre);
    n_tests++;
    if (pre !== e) begin
      n_fail++;
      $display("ERROR %0t flag %b exp %b", $time, pre, e);
    end
  endtask : chk_ter

  initial begin
    #500us;
    n_fail++;
    end_sim();
  end

  initial begin
    n_fail  = 0;
    n_tests = 0;
    rst_n   = 1'b0;
    ctrl    = '{logic_ok: 1'b1, analog_ok: 1'b1, enable: 1'b1, limp: 1'b0};
    pin     = '0;
    sense   = '0;
    void'($urandom(29));
    step(16);
    rst_n = 1'b1;
    step(8);
    chk_drv(8'h00, 8'h00);
    chk_ter(1'b0, 1'b1);
    send(32, {16'hc3a5, 16'haaaa});
    chk_ser({16'h0000, 16'hc3a5});
    chk_drv(8'hff, 8'h00);
    chk_ter(1'b0, 1'b0);
    chk_ter(1'b1, 1'b1);
    // short or ragged frames: command kept, flag raised
    foreach (bad_len[k]) begin
      send(bad_len[k], $urandom);
      chk_drv(8'hff, 8'h00);
      chk_ter(1'b0, 1'b1);
      send(16, 16'haaaa);
    end
    send(24, {8'h00, 8'h00, 16'h5555});
    pin = 4'hf;
    step(5);
    chk_drv(8'hff, 8'h00);
    for (int i = 0; i < 12; i++) begin
      c = (i < 4) ? ({16'h0000, 16'h5555, 16'haaaa, 16'hffff} >> (16 * (3 - i))) : $urandom;
      pin = $urandom;
      send(16, {16'h0000, c});
      eo = exp_drive(c, pin);
      chk_drv(eo, exp_diag(c, eo));
      pin = $urandom;
      step(5);
      eo = exp_drive(c, pin);
      chk_drv(eo, exp_diag(c, eo));
    end
    send(16, 16'haaaa);
    pulse({8'h04, 8'h20, 8'h00});
    chk_drv(8'hdb, 8'h00);
    send(16, 16'haaaa);
    chk_ser({16'h0, exp_stat(8'h00, 8'h24)});
    chk_drv(8'hdb, 8'h00);
    send(16, 16'haa8a);
    send(16, 16'haaab);
    chk_ser({16'h0, exp_stat(8'h00, 8'h20)});
    chk_drv(8'hde, 8'h01);
    pulse({8'h00, 8'h00, 8'h01});
    send(16, 16'haaaa);
    chk_ser({16'h0, exp_stat(8'h01, 8'h20)});
    chk_drv(8'hdf, 8'h00);
    // limp: inputs drive channels 1 to 4, commands ignored, faults still kept
    ctrl.limp = 1'b1;
    pin = 4'ha;
    step(6);
    send(16, 16'haaaa);
    chk_drv(8'h0a, 8'h00);
    pulse({8'h02, 8'h00, 8'h00});
    chk_drv(8'h08, 8'h00);
    send(16, 16'haaaa);
    chk_ser({16'h0, exp_stat(8'h01, 8'h22)});
    ctrl.limp = 1'b0;
    step(6);
    chk_drv(8'h00, 8'h00);
    chk_ter(1'b0, 1'b1);
    send(16, 16'haaaa);
    chk_ser({16'h0, exp_stat(8'h00, 8'h00)});
    pulse({8'h80, 8'h00, 8'h00});
    ctrl.enable = 1'b0;
    step(6);
    ctrl.enable = 1'b1;
    step(6);
    chk_drv(8'h00, 8'h00);
    chk_ter(1'b0, 1'b1);
    send(16, 16'haaaa);
    chk_ser({16'h0, exp_stat(8'h00, 8'h00)});
    end_sim();
  end
endmodule : test_octal_driver_spi_fault_logic
`default_nettype wire
